// ---- ufc_uart_regs.sv ----
// Interrupt identification, FIFO control and enhanced feature logic of a UART.
`timescale 1ns/10ps
`default_nettype none

module ufc_uart_regs #(
	parameter int DEPTH = ufc_pkg::FIFO_DEPTH_DEF
) (
	// Clock and resets.
	input  wire logic       i_clk,
	input  wire logic       i_arst_n,
	input  wire logic       i_soft_rst,
	// Host register port.
	input  wire logic       i_reg_wr,
	input  wire logic       i_reg_rd,
	input  wire logic [2:0] i_reg_addr,
	input  wire logic [7:0] i_reg_wdata,
	output logic      [7:0] o_reg_rdata,
	// Settings held by neighbouring registers.
	input  wire logic       i_special_function_hide,
	input  wire logic [7:0] i_interrupt_enable,
	input  wire logic [7:0] i_first_resume_char,
	input  wire logic [7:0] i_second_resume_char,
	input  wire logic [7:0] i_first_pause_char,
	input  wire logic [7:0] i_second_pause_char,
	// Interrupt sources from the line side.
	input  wire logic       i_line_status_event,
	input  wire logic       i_rx_timeout,
	input  wire logic       i_modem_change,
	input  wire logic       i_flow_inactive,
	// Characters from the receive shifter.
	input  wire logic       i_rx_valid,
	input  wire logic [7:0] i_rx_data,
	output logic            o_rx_ready,
	// Characters to the transmit shifter.
	output logic            o_tx_valid,
	output logic      [7:0] o_tx_data,
	input  wire logic       i_tx_ready,
	// Controls for the rest of the UART.
	output logic      [7:0] o_line_control,
	output logic            o_auto_cts_en,
	output logic            o_auto_rts_en,
	output logic      [1:0] o_tx_flow_pair,
	output logic            o_enhanced_write_en,
	output logic            o_sleep_allowed,
	output logic            o_tx_paused
);
	import ufc_pkg::*;

	localparam int PW = $clog2(DEPTH);
	localparam int CW = PW + 1;

	typedef struct packed {
		logic [7:0]               line_control;
		logic [7:0]               enhanced_features;
		logic                     fifo_en;
		logic [1:0]               rx_trig;
		logic [1:0]               tx_trig;
		logic [7:0]               interrupt_ident;
		logic [7:0]               rdata;
		logic [DEPTH-1:0][7:0]    rx_mem;
		logic [PW-1:0]            rx_wp;
		logic [PW-1:0]            rx_rp;
		logic [CW-1:0]            rx_cnt;
		logic [DEPTH-1:0][7:0]    tx_mem;
		logic [PW-1:0]            tx_wp;
		logic [PW-1:0]            tx_rp;
		logic [CW-1:0]            tx_cnt;
		logic [1:0][7:0]          sk_data;
		logic                     sk_wp;
		logic                     sk_rp;
		logic [1:0]               sk_cnt;
		logic [7:0]               tx_out;
		logic                     tx_out_v;
		logic                     paused;
		logic                     xoff_int;
		logic                     spec_int;
		logic                     seq_off;
		logic                     seq_on;
	} ufc_state_type;

	ufc_state_type s_r;
	ufc_state_type s_nxt;

	ufc_sel_type   sel;
	logic          host_path;
	logic          fcr_wr;
	logic          efr_wr;
	logic          iir_rd;
	logic          mode_flip;
	logic          rx_flush;
	logic          tx_flush;
	logic [CW-1:0] cap;
	logic [CW-1:0] rx_lvl;
	logic [CW-1:0] tx_lvl;
	logic [CW-1:0] tx_free;
	logic [7:0]    head;
	logic          cmp_p1;
	logic          cmp_p2;
	logic          cmp_seq;
	logic          hit_off;
	logic          hit_on;
	logic          seq_first;
	logic          absorb;
	logic          spec_hit;
	logic          drain;
	logic          rx_push;
	logic          rx_pop;
	logic          sk_push;
	logic          tx_push;
	logic          tx_load;
	logic [6:0]    srcs;
	logic [5:0]    code;

	// Address 2 decode, shared by reads and writes.
	assign sel       = ufc_sel_shared(s_r.line_control, i_special_function_hide);
	assign host_path = !s_r.line_control[LCR_DIV_BIT];
	assign fcr_wr    = i_reg_wr && i_reg_addr == ADDR_SHARED && sel == SEL_IIR_FCR;
	assign efr_wr    = i_reg_wr && i_reg_addr == ADDR_SHARED && sel == SEL_EFR;
	assign iir_rd    = i_reg_rd && i_reg_addr == ADDR_SHARED && sel == SEL_IIR_FCR;

	// Switching FIFO mode empties both FIFOs so a disabled FIFO never holds more than one word.
	assign mode_flip = fcr_wr && i_reg_wdata[FCR_EN_BIT] != s_r.fifo_en;
	assign rx_flush  = mode_flip || (fcr_wr && i_reg_wdata[FCR_EN_BIT]
	                   && i_reg_wdata[FCR_RXRST_BIT]);
	assign tx_flush  = mode_flip || (fcr_wr && i_reg_wdata[FCR_EN_BIT]
	                   && i_reg_wdata[FCR_TXRST_BIT]);

	// Capacity and trigger levels.
	assign cap     = s_r.fifo_en ? CW'(DEPTH) : CW'(LEVEL_SINGLE);
	assign rx_lvl  = s_r.fifo_en ? CW'(ufc_rx_level(s_r.rx_trig)) : CW'(LEVEL_SINGLE);
	assign tx_lvl  = !s_r.fifo_en ? CW'(LEVEL_SINGLE) :
	                 s_r.enhanced_features[EFR_ENH_BIT] ? CW'(ufc_tx_level(s_r.tx_trig)) :
	                 CW'(TX_TRIG_00);
	assign tx_free = cap - s_r.tx_cnt;

	// Receive flow character comparison.
	assign head    = s_r.sk_data[s_r.sk_rp];
	assign cmp_seq = s_r.enhanced_features[1:0] == 2'b11 && (s_r.enhanced_features[3:2] == 2'b11 || s_r.enhanced_features[3:2] == 2'b00);
	assign cmp_p1  = s_r.enhanced_features[1:0] == 2'b10 || (s_r.enhanced_features[1:0] == 2'b11 && !cmp_seq);
	assign cmp_p2  = s_r.enhanced_features[1:0] == 2'b01 || (s_r.enhanced_features[1:0] == 2'b11 && !cmp_seq);
	assign hit_off = (cmp_p1 && head == i_first_pause_char)
	                 || (cmp_p2 && head == i_second_pause_char)
	                 || (cmp_seq && s_r.seq_off && head == i_second_pause_char);
	assign hit_on  = (cmp_p1 && head == i_first_resume_char)
	                 || (cmp_p2 && head == i_second_resume_char)
	                 || (cmp_seq && s_r.seq_on && head == i_second_resume_char);
	assign seq_first = cmp_seq && (head == i_first_pause_char || head == i_first_resume_char);
	assign absorb    = hit_off || hit_on || seq_first;
	assign spec_hit  = s_r.enhanced_features[EFR_SPEC_BIT] && head == i_second_pause_char;

	// Two-entry buffer ahead of the receive FIFO; a full FIFO stalls the shifter, not loses data.
	assign o_rx_ready = s_r.sk_cnt != 2'h2;
	assign sk_push    = i_rx_valid && o_rx_ready;
	assign drain      = s_r.sk_cnt != 2'h0 && !rx_flush && (absorb || s_r.rx_cnt < cap);
	assign rx_push    = drain && !absorb;
	assign rx_pop     = i_reg_rd && i_reg_addr == ADDR_HOLDING && host_path
	                    && s_r.rx_cnt != '0 && !rx_flush;
	assign tx_push    = i_reg_wr && i_reg_addr == ADDR_HOLDING && host_path
	                    && s_r.tx_cnt < cap && !tx_flush;
	// The shifter stage is not emptied by a transmit reset.
	assign tx_load    = s_r.tx_cnt != '0 && (!s_r.tx_out_v || i_tx_ready) && !s_r.paused
	                    && !tx_flush;

	// Pending sources, highest priority in bit 6.
	assign srcs[6] = i_line_status_event && i_interrupt_enable[IER_LSR_BIT];
	assign srcs[5] = i_rx_timeout && i_interrupt_enable[IER_RX_BIT];
	assign srcs[4] = s_r.rx_cnt != '0 && s_r.rx_cnt >= rx_lvl && i_interrupt_enable[IER_RX_BIT];
	assign srcs[3] = tx_free >= tx_lvl && i_interrupt_enable[IER_THR_BIT];
	assign srcs[2] = i_modem_change && i_interrupt_enable[IER_MSR_BIT];
	assign srcs[1] = (s_r.xoff_int || s_r.spec_int) && i_interrupt_enable[IER_XOFF_BIT]
	                 && s_r.enhanced_features[EFR_ENH_BIT];
	assign srcs[0] = i_flow_inactive && s_r.enhanced_features[EFR_ENH_BIT]
	                 && (i_interrupt_enable[IER_CTS_BIT] || i_interrupt_enable[IER_RTS_BIT]);

	always_comb begin
		if (srcs[6]) begin
			code = IIR_CODE_LSR;
		end else if (srcs[5]) begin
			code = IIR_CODE_TMO;
		end else if (srcs[4]) begin
			code = IIR_CODE_RHR;
		end else if (srcs[3]) begin
			code = IIR_CODE_THR;
		end else if (srcs[2]) begin
			code = IIR_CODE_MSR;
		end else if (srcs[1]) begin
			code = IIR_CODE_XOFF;
		end else if (srcs[0]) begin
			code = IIR_CODE_FLOW;
		end else begin
			code = IIR_CODE_NONE;
		end
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.interrupt_ident = {s_r.fifo_en, s_r.fifo_en, code};

		if (sk_push) begin
			s_nxt.sk_data[s_r.sk_wp] = i_rx_data;
			s_nxt.sk_wp = ~s_r.sk_wp;
		end
		if (drain) begin
			s_nxt.sk_rp = ~s_r.sk_rp;
		end
		s_nxt.sk_cnt = s_r.sk_cnt + {1'b0, sk_push} - {1'b0, drain};

		if (rx_push) begin
			s_nxt.rx_mem[s_r.rx_wp] = head;
			s_nxt.rx_wp = s_r.rx_wp + PW'(1);
		end
		if (rx_pop) begin
			s_nxt.rx_rp = s_r.rx_rp + PW'(1);
		end
		s_nxt.rx_cnt = s_r.rx_cnt + CW'(rx_push) - CW'(rx_pop);
		if (rx_flush) begin
			s_nxt.rx_wp  = '0;
			s_nxt.rx_rp  = '0;
			s_nxt.rx_cnt = '0;
		end

		if (tx_push) begin
			s_nxt.tx_mem[s_r.tx_wp] = i_reg_wdata;
			s_nxt.tx_wp = s_r.tx_wp + PW'(1);
		end
		if (tx_load) begin
			s_nxt.tx_out = s_r.tx_mem[s_r.tx_rp];
			s_nxt.tx_rp  = s_r.tx_rp + PW'(1);
		end
		if (tx_load) begin
			s_nxt.tx_out_v = 1'b1;
		end else if (i_tx_ready) begin
			s_nxt.tx_out_v = 1'b0;
		end
		s_nxt.tx_cnt = s_r.tx_cnt + CW'(tx_push) - CW'(tx_load);
		if (tx_flush) begin
			s_nxt.tx_wp  = '0;
			s_nxt.tx_rp  = '0;
			s_nxt.tx_cnt = '0;
		end

		// Clears first, sets after, so an event in the clearing cycle survives.
		if (drain && hit_on) begin
			s_nxt.xoff_int = 1'b0;
			s_nxt.paused   = 1'b0;
		end
		if (iir_rd) begin
			s_nxt.spec_int = 1'b0;
		end
		if (drain && hit_off) begin
			s_nxt.xoff_int = 1'b1;
			s_nxt.paused   = 1'b1;
		end
		if (drain && spec_hit) begin
			s_nxt.spec_int = 1'b1;
		end
		if (drain) begin
			s_nxt.seq_off = cmp_seq && head == i_first_pause_char;
			s_nxt.seq_on  = cmp_seq && head == i_first_resume_char;
		end

		if (fcr_wr) begin
			s_nxt.fifo_en = i_reg_wdata[FCR_EN_BIT];
			if (i_reg_wdata[FCR_EN_BIT]) begin
				s_nxt.rx_trig = i_reg_wdata[FCR_RXTRIG_LSB +: 2];
				if (s_r.enhanced_features[EFR_ENH_BIT]) begin
					s_nxt.tx_trig = i_reg_wdata[FCR_TXTRIG_LSB +: 2];
				end
			end
		end
		if (efr_wr) begin
			s_nxt.enhanced_features = i_reg_wdata;
		end
		if (i_reg_wr && i_reg_addr == ADDR_LINE_CTRL) begin
			s_nxt.line_control = i_reg_wdata;
		end

		if (i_reg_rd) begin
			case (i_reg_addr)
				ADDR_HOLDING:   s_nxt.rdata = (host_path && s_r.rx_cnt != '0)
				                              ? s_r.rx_mem[s_r.rx_rp] : 8'h00;
				ADDR_SHARED:    s_nxt.rdata = (sel == SEL_IIR_FCR) ? s_r.interrupt_ident :
				                              (sel == SEL_EFR) ? s_r.enhanced_features : 8'h00;
				ADDR_LINE_CTRL: s_nxt.rdata = s_r.line_control;
				default:        s_nxt.rdata = 8'h00;
			endcase
		end

		// A software reset leaves the identification register alone.
		if (i_soft_rst) begin
			s_nxt     = '0;
			s_nxt.line_control = LINE_CONTROL_RST;
			s_nxt.interrupt_ident = s_r.interrupt_ident;
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_r     <= '0;
			s_r.line_control <= LINE_CONTROL_RST;
			s_r.interrupt_ident <= INTERRUPT_IDENT_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign o_reg_rdata         = s_r.rdata;
	assign o_tx_valid          = s_r.tx_out_v;
	assign o_tx_data           = s_r.tx_out;
	assign o_line_control      = s_r.line_control;
	assign o_auto_cts_en       = s_r.enhanced_features[EFR_CTS_BIT];
	assign o_auto_rts_en       = s_r.enhanced_features[EFR_RTS_BIT];
	assign o_tx_flow_pair      = s_r.enhanced_features[3:2];
	assign o_enhanced_write_en = s_r.enhanced_features[EFR_ENH_BIT];
	assign o_sleep_allowed     = s_r.enhanced_features[EFR_ENH_BIT];
	assign o_tx_paused         = s_r.paused;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	property p_iir_read;
		i_reg_rd && i_reg_addr == ADDR_SHARED && !s_r.line_control[LCR_DIV_BIT] && !i_soft_rst
		|=> o_reg_rdata == $past(s_r.interrupt_ident);
	endproperty
	a_iir_read: assert property (p_iir_read) else $error("identification read mismatch");

	property p_soft_keeps_iir;
		i_soft_rst |=> s_r.interrupt_ident == $past(s_r.interrupt_ident) && s_r.line_control == LINE_CONTROL_RST;
	endproperty
	a_soft_keeps_iir: assert property (p_soft_keeps_iir) else $error("soft reset hit ident");

	property p_mirror;
		!i_soft_rst |=> s_r.interrupt_ident[7:6] == {2{$past(s_r.fifo_en)}};
	endproperty
	a_mirror: assert property (p_mirror) else $error("ident bits 7:6 wrong");

	property p_none_pending;
		s_r.interrupt_ident[0] |-> s_r.interrupt_ident[5:1] == 5'h00;
	endproperty
	a_none_pending: assert property (p_none_pending) else $error("pending flag wrong");

	property p_lsr_top;
		srcs[6] && !i_soft_rst |=> s_r.interrupt_ident[5:0] == IIR_CODE_LSR;
	endproperty
	a_lsr_top: assert property (p_lsr_top) else $error("line status not reported");

	property p_spec_clear;
		iir_rd && !(drain && spec_hit) && !i_soft_rst |=> !s_r.spec_int;
	endproperty
	a_spec_clear: assert property (p_spec_clear) else $error("special flag not cleared");

	property p_tx_flush;
		tx_flush && !i_soft_rst |=> s_r.tx_cnt == '0 ##1 s_r.tx_cnt <= CW'(1);
	endproperty
	a_tx_flush: assert property (p_tx_flush) else $error("transmit reset failed");

	property p_rx_flush;
		rx_flush && !i_soft_rst |=> s_r.rx_cnt == '0;
	endproperty
	a_rx_flush: assert property (p_rx_flush) else $error("receive reset failed");

	property p_single;
		!s_r.fifo_en |-> s_r.rx_cnt <= CW'(1) && s_r.tx_cnt <= CW'(1);
	endproperty
	a_single: assert property (p_single) else $error("disabled FIFO over one");

	property p_efr_locked;
		i_reg_wr && i_reg_addr == ADDR_SHARED && sel != SEL_EFR && !i_soft_rst
		|=> $stable(s_r.enhanced_features);
	endproperty
	a_efr_locked: assert property (p_efr_locked) else $error("enhanced reg written");

	property p_pause_absorbed;
		drain && hit_off && !i_soft_rst |-> !rx_push ##1 s_r.paused;
	endproperty
	a_pause_absorbed: assert property (p_pause_absorbed) else $error("pause char stored");

	c_fifo_full:  cover property (s_r.fifo_en && s_r.rx_cnt == CW'(DEPTH));
	c_pause_seen: cover property (drain && hit_off ##[1:20] drain && hit_on);
	c_special:    cover property (drain && spec_hit && !hit_off);
	c_rx_stall:   cover property (i_rx_valid && !o_rx_ready);

endmodule : ufc_uart_regs

`default_nettype wire

// ---- ufc_pkg.sv ----
// Constants, types and decode functions shared by the UART register and FIFO logic.
package ufc_pkg;

	// Host port register addresses.
	localparam logic [2:0] ADDR_HOLDING   = 3'h0;
	localparam logic [2:0] ADDR_SHARED    = 3'h2;
	localparam logic [2:0] ADDR_LINE_CTRL = 3'h3;

	// Values after power-on reset.
	localparam logic [7:0] LINE_CONTROL_RST    = 8'h1d;
	localparam logic [7:0] INTERRUPT_IDENT_RST = 8'h01;

	// Line control layout and the key value that opens the enhanced register.
	localparam int         LCR_DIV_BIT  = 7;
	localparam logic [7:0] LCR_EFR_KEY  = 8'hbf;

	// FIFO control field positions.
	localparam int FCR_EN_BIT      = 0;
	localparam int FCR_RXRST_BIT   = 1;
	localparam int FCR_TXRST_BIT   = 2;
	localparam int FCR_TXTRIG_LSB  = 4;
	localparam int FCR_RXTRIG_LSB  = 6;

	// Enhanced feature field positions.
	localparam int EFR_CTS_BIT  = 7;
	localparam int EFR_RTS_BIT  = 6;
	localparam int EFR_SPEC_BIT = 5;
	localparam int EFR_ENH_BIT  = 4;

	// Interrupt enable bit positions (the register itself lives outside this block).
	localparam int IER_RX_BIT    = 0;
	localparam int IER_THR_BIT   = 1;
	localparam int IER_LSR_BIT   = 2;
	localparam int IER_MSR_BIT   = 3;
	localparam int IER_XOFF_BIT  = 5;
	localparam int IER_RTS_BIT   = 6;
	localparam int IER_CTS_BIT   = 7;

	// Identification codes for bits 5:0, in descending priority.
	localparam logic [5:0] IIR_CODE_LSR  = 6'h06;
	localparam logic [5:0] IIR_CODE_TMO  = 6'h0c;
	localparam logic [5:0] IIR_CODE_RHR  = 6'h04;
	localparam logic [5:0] IIR_CODE_THR  = 6'h02;
	localparam logic [5:0] IIR_CODE_MSR  = 6'h00;
	localparam logic [5:0] IIR_CODE_XOFF = 6'h10;
	localparam logic [5:0] IIR_CODE_FLOW = 6'h20;
	localparam logic [5:0] IIR_CODE_NONE = 6'h01;

	// FIFO sizing and trigger levels in characters or spaces.
	localparam int         FIFO_DEPTH_DEF = 64;
	localparam logic [6:0] LEVEL_SINGLE   = 7'h01;
	localparam logic [6:0] RX_TRIG_00     = 7'h08;
	localparam logic [6:0] RX_TRIG_01     = 7'h10;
	localparam logic [6:0] RX_TRIG_10     = 7'h38;
	localparam logic [6:0] RX_TRIG_11     = 7'h3c;
	localparam logic [6:0] TX_TRIG_00     = 7'h08;
	localparam logic [6:0] TX_TRIG_01     = 7'h10;
	localparam logic [6:0] TX_TRIG_10     = 7'h20;
	localparam logic [6:0] TX_TRIG_11     = 7'h38;

	// What address 2 reaches for the current line control value.
	typedef enum logic [1:0] {
		SEL_IIR_FCR = 2'b00,
		SEL_EFR     = 2'b01,
		SEL_DIVISOR = 2'b10
	} ufc_sel_type;

	function automatic ufc_sel_type ufc_sel_shared(input logic [7:0] line_control, input logic hide);
		if (line_control == LCR_EFR_KEY && !hide) begin
			return SEL_EFR;
		end else if (!line_control[LCR_DIV_BIT]) begin
			return SEL_IIR_FCR;
		end
		return SEL_DIVISOR;
	endfunction : ufc_sel_shared

	function automatic logic [6:0] ufc_rx_level(input logic [1:0] code);
		case (code)
			2'b00:   return RX_TRIG_00;
			2'b01:   return RX_TRIG_01;
			2'b10:   return RX_TRIG_10;
			default: return RX_TRIG_11;
		endcase
	endfunction : ufc_rx_level

	function automatic logic [6:0] ufc_tx_level(input logic [1:0] code);
		case (code)
			2'b00:   return TX_TRIG_00;
			2'b01:   return TX_TRIG_01;
			2'b10:   return TX_TRIG_10;
			default: return TX_TRIG_11;
		endcase
	endfunction : ufc_tx_level

endpackage : ufc_pkg

// ---- ufc_line_model.sv ----
// Line-side model: feeds received characters and drains transmitted ones.
`timescale 1ns/10ps
`default_nettype none

module ufc_line_model #(
	parameter int STALL = 3
) (
	input  wire logic       i_clk,
	output logic            o_rx_valid,
	output logic      [7:0] o_rx_data,
	input  wire logic       i_rx_ready,
	input  wire logic       i_tx_valid,
	input  wire logic [7:0] i_tx_data,
	output logic            o_tx_ready
);
	logic [7:0] pend[$];
	logic [7:0] got[$];
	logic [7:0] last = 8'h00;
	int         cnt  = 0;

	initial begin
		o_rx_valid = 1'b0;
		o_rx_data  = 8'hff;
		o_tx_ready = 1'b0;
	end

	task automatic send(input logic [7:0] c);
		pend.push_back(c);
	endtask : send

	always @(posedge i_clk) begin
		if (o_rx_valid && i_rx_ready) begin
			last = pend.pop_front();
		end
		if (i_tx_valid && o_tx_ready) begin
			got.push_back(i_tx_data);
		end
		cnt = cnt + 1;
		#2;
		o_rx_valid = (pend.size() > 0);
		// An idle data line shows the inverse of the last character, never a stale copy.
		o_rx_data  = o_rx_valid ? pend[0] : ~last;
		// Stall the transmit side now and then, as a slow shifter would.
		o_tx_ready = (cnt % STALL) != 0;
	end
endmodule : ufc_line_model
`default_nettype wire

// ---- uart_irq_fifo_flow_ctrl_test.sv ----
// Self-checking testbench for the UART identification, FIFO and enhanced feature logic.
`timescale 1ns/10ps
`default_nettype none

module uart_irq_fifo_flow_ctrl_test;
	import ufc_pkg::*;
	logic       clk = 1'b0, arst_n = 1'b0, soft_rst = 1'b0, wr = 1'b0, rd = 1'b0, hide = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00, rdata, interrupt_enable = 8'h00, q, line_control;
	logic [3:0] src = 4'h0;
	logic       rxv, rxr, txv, txr, cts, rts, enh, slp, paused;
	logic [7:0] rxd, txd;
	logic [1:0] pair;
	logic [15:0] lfsr = 16'd43455;
	logic [7:0] exp_q[$];
	int         fails = 0, n_checks = 0;
	logic [7:0] tab_ier[4] = '{8'h05, 8'h01, 8'h02, 8'h08};
	logic [3:0] tab_src[4] = '{4'hc, 4'h4, 4'h0, 4'h2};
	logic [5:0] tab_code[4] = '{IIR_CODE_LSR, IIR_CODE_TMO, IIR_CODE_THR, IIR_CODE_MSR};
	// Flow characters: first resume, second resume, first pause, second pause.
	logic [7:0] fc[4] = '{8'h11, 8'h12, 8'h13, 8'h14};

	always #12.5 clk = ~clk;

	ufc_uart_regs DUT (.i_clk(clk), .i_arst_n(arst_n), .i_soft_rst(soft_rst), .i_reg_wr(wr),
		.i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
		.i_special_function_hide(hide), .i_interrupt_enable(interrupt_enable),
		.i_first_resume_char(fc[0]), .i_second_resume_char(fc[1]),
		.i_first_pause_char(fc[2]), .i_second_pause_char(fc[3]),
		.i_line_status_event(src[3]), .i_rx_timeout(src[2]), .i_modem_change(src[1]),
		.i_flow_inactive(src[0]), .i_rx_valid(rxv), .i_rx_data(rxd), .o_rx_ready(rxr),
		.o_tx_valid(txv), .o_tx_data(txd), .i_tx_ready(txr), .o_line_control(line_control),
		.o_auto_cts_en(cts), .o_auto_rts_en(rts), .o_tx_flow_pair(pair),
		.o_enhanced_write_en(enh), .o_sleep_allowed(slp), .o_tx_paused(paused));

	ufc_line_model line (.i_clk(clk), .o_rx_valid(rxv), .o_rx_data(rxd), .i_rx_ready(rxr),
		.i_tx_valid(txv), .i_tx_data(txd), .o_tx_ready(txr));

	function automatic logic [7:0] ident(input logic en, input logic [5:0] code);
		return {en, en, code};
	endfunction : ident

	// Random characters stay clear of the flow characters 0x11 to 0x15.
	function automatic logic [7:0] next_char();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return {2'b01, lfsr[5:0]};
	endfunction : next_char

	task automatic chk(input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, seen, want);
		end
	endtask : chk

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk) #2;
		wr    = 1'b1;
		addr  = a;
		wdata = d;
		@(posedge clk) #2;
		wr = 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk) #2;
		rd   = 1'b1;
		addr = a;
		@(posedge clk) #2;
		rd = 1'b0;
		d  = rdata;
	endtask : rd_reg

	task automatic send_rand(input int n);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back(next_char());
			line.send(exp_q[$]);
		end
		repeat (n + 8) @(posedge clk);
	endtask : send_rand

	task automatic conclude();
		$display("Checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : conclude

	initial begin
		#500000;
		fails++;
		conclude();
	end

	initial begin
		repeat (2) @(posedge clk);
		#2 arst_n = 1'b1;
		rd_reg(ADDR_SHARED, q); chk(q, INTERRUPT_IDENT_RST);
		rd_reg(ADDR_LINE_CTRL, q); chk(q, LINE_CONTROL_RST);
		wr_reg(ADDR_SHARED, 8'h01);
		rd_reg(ADDR_SHARED, q); chk(q, ident(1'b1, IIR_CODE_NONE));
		for (int i = 0; i < 4; i++) begin
			interrupt_enable = tab_ier[i];
			src = tab_src[i];
			repeat (2) @(posedge clk);
			rd_reg(ADDR_SHARED, q); chk(q, ident(1'b1, tab_code[i]));
		end
		interrupt_enable = 8'h01;
		src = 4'h0;
		send_rand(7);
		rd_reg(ADDR_SHARED, q); chk(q, ident(1'b1, IIR_CODE_NONE));
		send_rand(1);
		rd_reg(ADDR_SHARED, q); chk(q, ident(1'b1, IIR_CODE_RHR));
		while (exp_q.size() > 0) begin
			rd_reg(ADDR_HOLDING, q); chk(q, exp_q.pop_front());
		end
		send_rand(3);
		wr_reg(ADDR_SHARED, 8'h03);
		repeat (3) @(posedge clk);
		rd_reg(ADDR_HOLDING, q); chk(q, 8'h00);
		exp_q.delete();
		for (int i = 0; i < 3; i++) begin
			exp_q.push_back(next_char());
			wr_reg(ADDR_HOLDING, exp_q[i]);
		end
		repeat (30) @(posedge clk);
		for (int i = 0; i < 3; i++) begin
			chk(line.got[i], exp_q[i]);
		end
		wr_reg(ADDR_LINE_CTRL, LCR_EFR_KEY);
		wr_reg(ADDR_SHARED, 8'hd6);
		rd_reg(ADDR_SHARED, q); chk(q, 8'hd6);
		chk({cts, rts, enh, slp, 2'b00, pair}, 8'hf1);
		hide = 1'b1;
		rd_reg(ADDR_SHARED, q); chk(q, 8'h00);
		hide = 1'b0;
		wr_reg(ADDR_LINE_CTRL, 8'h80);
		rd_reg(ADDR_SHARED, q); chk(q, 8'h00);
		wr_reg(ADDR_LINE_CTRL, 8'h03);
		interrupt_enable = 8'h20;
		line.send(8'h13);
		repeat (8) @(posedge clk);
		#2;
		chk({7'h00, paused}, 8'h01);
		rd_reg(ADDR_SHARED, q); chk(q, ident(1'b1, IIR_CODE_XOFF));
		line.send(8'h11);
		repeat (8) @(posedge clk);
		#2;
		chk({7'h00, paused}, 8'h00);
		rd_reg(ADDR_SHARED, q); chk(q, ident(1'b1, IIR_CODE_NONE));
		rd_reg(ADDR_HOLDING, q); chk(q, 8'h00);
		wr_reg(ADDR_LINE_CTRL, LCR_EFR_KEY);
		wr_reg(ADDR_SHARED, 8'hf6);
		wr_reg(ADDR_LINE_CTRL, 8'h03);
		fc[3] = 8'h15;
		line.send(8'h15);
		repeat (8) @(posedge clk);
		rd_reg(ADDR_SHARED, q); chk(q, ident(1'b1, IIR_CODE_XOFF));
		repeat (2) @(posedge clk);
		rd_reg(ADDR_SHARED, q); chk(q, ident(1'b1, IIR_CODE_NONE));
		rd_reg(ADDR_HOLDING, q); chk(q, 8'h15);
		// Flow-inactive source is only visible with the enhanced enable set.
		interrupt_enable = 8'h40;
		src = 4'h1;
		repeat (2) @(posedge clk);
		rd_reg(ADDR_SHARED, q); chk(q, ident(1'b1, IIR_CODE_FLOW));
		interrupt_enable = 8'h01;
		src = 4'h0;
		// With the FIFO off one character is held and the buffer takes the stalled rest.
		wr_reg(ADDR_SHARED, 8'h00);
		exp_q.delete();
		send_rand(3);
		rd_reg(ADDR_SHARED, q); chk(q, ident(1'b0, IIR_CODE_RHR));
		while (exp_q.size() > 0) begin
			rd_reg(ADDR_HOLDING, q); chk(q, exp_q.pop_front());
		end
		@(posedge clk) #2 soft_rst = 1'b1;
		@(posedge clk) #2 soft_rst = 1'b0;
		chk(line_control, LINE_CONTROL_RST);
		conclude();
	end
endmodule : uart_irq_fifo_flow_ctrl_test
`default_nettype wire
